// File: include/mpf_pkg.sv
// mpf_pkg: register map, field layout, reset values and timing of the pause flow unit
// assumes one 25 MHz pclk shared by the APB slave and the MAC datapath

package mpf_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // register indices; byte address is four times the index
   localparam logic [7:0]  MODE_IDX  = 8'h00;
   localparam logic [7:0]  STAT_IDX  = 8'h01;
   localparam logic [7:0]  FLOW_IDX  = 8'h08;
   localparam logic [7:0]  MODE_ADDR = {MODE_IDX[5:0], 2'b00};
   localparam logic [7:0]  STAT_ADDR = {STAT_IDX[5:0], 2'b00};
   localparam logic [7:0]  FLOW_ADDR = {FLOW_IDX[5:0], 2'b00};

   ////////////////////////////////////////////////////////////////////////////////
   // field positions
   localparam int unsigned PT_MSB    = 31;
   localparam int unsigned PT_LSB    = 16;
   localparam int unsigned PASS_BIT  = 2;
   localparam int unsigned FLOW_CTRL_ENABLE_BIT  = 1;
   localparam int unsigned BUSY_BIT  = 0;
   localparam int unsigned FD_BIT    = 0;
   localparam int unsigned TXEN_BIT  = 1;
   localparam int unsigned SPD_BIT   = 2;
   localparam int unsigned HOLD_BIT  = 0;
   localparam int unsigned REM_LSB   = 16;

   ////////////////////////////////////////////////////////////////////////////////
   // reset values
   localparam logic [31:0] FLOW_RST  = 32'h0000_0000;
   localparam logic [31:0] MODE_RST  = 32'h0000_0000;

   ////////////////////////////////////////////////////////////////////////////////
   // timing: one pause quantum is one slot time of 512 bit times
   localparam int unsigned CLK_NS     = 40;
   localparam int unsigned SLOT_BITS  = 512;
   localparam int unsigned BIT_NS_100 = 10;
   localparam int unsigned BIT_NS_10  = 100;
   localparam logic [10:0] QCYC_100   = 11'(SLOT_BITS * BIT_NS_100 / CLK_NS);
   localparam logic [10:0] QCYC_10    = 11'(SLOT_BITS * BIT_NS_10 / CLK_NS);

   ////////////////////////////////////////////////////////////////////////////////
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_FRAME = 2'b01,
      ST_BACKP = 2'b10
   } mpf_tx_state_t;

   typedef enum logic [1:0] {
      SEL_NONE = 2'b00,
      SEL_MODE = 2'b01,
      SEL_STAT = 2'b10,
      SEL_FLOW = 2'b11
   } mpf_sel_t;

   function automatic mpf_sel_t mpf_decode(input logic [7:0] addr);
      mpf_sel_t sel;
      sel = SEL_NONE;
      if (addr == MODE_ADDR) begin
         sel = SEL_MODE;
      end else if (addr == STAT_ADDR) begin
         sel = SEL_STAT;
      end else if (addr == FLOW_ADDR) begin
         sel = SEL_FLOW;
      end
      return sel;
   endfunction

endpackage

// File: include/mpf_quanta_if.sv
// mpf_quanta_if: load and status lines between flow control and its pause timer
// assumes both ends sit on the same pclk
interface mpf_quanta_if;
   logic        load;
   logic [15:0] quanta;
   logic        speed_100;
   logic        paused;
   logic [15:0] remaining;

   modport ctl (output load, output quanta, output speed_100,
                input paused, input remaining);
   modport tmr (input load, input quanta, input speed_100,
                output paused, output remaining);
endinterface

// File: logic/mpf_quanta_timer.sv
// mpf_quanta_timer: counts pause quanta of one slot time each
// assumes load is a single-cycle pulse from the flow control block on pclk
module mpf_quanta_timer
   import mpf_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   mpf_quanta_if.tmr q
);

   logic [15:0] quanta_reg;
   logic [10:0] cyc_reg;
   logic [10:0] slot_cyc;

   assign slot_cyc    = q.speed_100 ? QCYC_100 : QCYC_10;
   assign q.paused    = (quanta_reg != 16'h0000);
   assign q.remaining = quanta_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // a new pause frame restarts the interval, even mid-count
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         quanta_reg <= 16'h0000;
         cyc_reg    <= 11'h000;
      end else if (q.load) begin
         quanta_reg <= q.quanta;
         cyc_reg    <= slot_cyc;
      end else if (quanta_reg != 16'h0000) begin
         if (cyc_reg == 11'h001) begin
            quanta_reg <= quanta_reg - 16'h0001;
            cyc_reg    <= slot_cyc;
         end else begin
            cyc_reg    <= cyc_reg - 11'h001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   AST_RESUME_ON_LAST: assert property (
      @(posedge pclk) disable iff (!presetn)
      (quanta_reg == 16'h0001 && cyc_reg == 11'h001 && !q.load) |=> !q.paused)
      else $error("pause did not end on the last quantum");

   AST_QUANTUM_HOLDS: assert property (
      @(posedge pclk) disable iff (!presetn)
      (q.load && q.quanta == 16'h0001 && q.speed_100) ##1 (!q.load)[*8] |-> q.paused)
      else $error("one quantum ended too early");

endmodule

// File: logic/mpf_flow_ctrl.sv
// mpf_flow_ctrl: pause and backpressure flow control with its APB register set
// assumes the MAC transmit and receive logic run on pclk; no input needs synchronising
//
// Implementation choice: the APB interface to the registers.
module mpf_flow_ctrl
   import mpf_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output wire logic        pready,
   output logic      [31:0] prdata,
   output wire logic        pslverr,
   input  wire logic        pause_tx_req,
   input  wire logic        bp_req,
   input  wire logic        tx_pause_done,
   output logic             tx_pause_start,
   output wire logic [15:0] tx_pause_time,
   output wire logic        backpressure,
   output wire logic        tx_hold,
   input  wire logic        rx_frame_end,
   input  wire logic        rx_good,
   input  wire logic        rx_is_pause,
   input  wire logic [15:0] rx_pause_time,
   input  wire logic        rx_addr_pass,
   input  wire logic        rx_filter_override,
   output logic             rx_status_valid,
   output logic             rx_status_filter,
   output logic             rx_status_ctrl
);

   ////////////////////////////////////////////////////////////////////////////////
   // register state
   logic [15:0]   pause_time_field_reg;
   logic          pass_control_frames_reg;
   logic          flow_ctrl_enable_reg;
   logic          full_duplex_reg;
   logic          tx_enable_reg;
   logic          speed_100_reg;
   logic          err_reg;
   mpf_tx_state_t state_reg;
   mpf_tx_state_t state_next;

   logic          setup_phase;
   logic          access_wr;
   mpf_sel_t      wr_sel;
   mpf_sel_t      rd_sel;
   logic          flow_ctrl_busy;
   logic          ctrl_seen;
   logic          pause_hit;
   logic          frame_go;
   logic          backp_ok;
   logic [31:0]   rd_value;

   mpf_quanta_if  qif ();

   ////////////////////////////////////////////////////////////////////////////////
   // apb slave: zero wait states, read data captured in the setup cycle
   assign setup_phase = psel && !penable;
   assign access_wr   = psel && penable && pwrite;
   assign wr_sel      = mpf_decode(paddr);
   assign rd_sel      = mpf_decode(paddr);
   assign pready      = 1'b1;
   assign pslverr     = psel && penable && err_reg;

   always_comb begin
      rd_value = 32'h0000_0000;
      case (rd_sel)
         SEL_FLOW: begin
            rd_value[PT_MSB:PT_LSB] = pause_time_field_reg;
            rd_value[PASS_BIT]      = pass_control_frames_reg;
            rd_value[FLOW_CTRL_ENABLE_BIT]      = flow_ctrl_enable_reg;
            rd_value[BUSY_BIT]      = flow_ctrl_busy;
         end
         SEL_MODE: begin
            rd_value[FD_BIT]   = full_duplex_reg;
            rd_value[TXEN_BIT] = tx_enable_reg;
            rd_value[SPD_BIT]  = speed_100_reg;
         end
         SEL_STAT: begin
            rd_value[HOLD_BIT]       = qif.paused;
            rd_value[REM_LSB +: 16]  = qif.remaining;
         end
         default: begin
            rd_value = 32'h0000_0000;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         err_reg <= 1'b0;
      end else if (setup_phase) begin
         prdata  <= pwrite ? 32'h0000_0000 : rd_value;
         err_reg <= (rd_sel == SEL_NONE);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // flow register; bit 0 is status only, so written data there is dropped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pause_time_field_reg    <= FLOW_RST[PT_MSB:PT_LSB];
         pass_control_frames_reg <= FLOW_RST[PASS_BIT];
         flow_ctrl_enable_reg    <= FLOW_RST[FLOW_CTRL_ENABLE_BIT];
      end else if (access_wr && wr_sel == SEL_FLOW) begin
         pause_time_field_reg    <= pwdata[PT_MSB:PT_LSB];
         pass_control_frames_reg <= pwdata[PASS_BIT];
         flow_ctrl_enable_reg    <= pwdata[FLOW_CTRL_ENABLE_BIT];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         full_duplex_reg <= MODE_RST[FD_BIT];
         tx_enable_reg   <= MODE_RST[TXEN_BIT];
         speed_100_reg   <= MODE_RST[SPD_BIT];
      end else if (access_wr && wr_sel == SEL_MODE) begin
         full_duplex_reg <= pwdata[FD_BIT];
         tx_enable_reg   <= pwdata[TXEN_BIT];
         speed_100_reg   <= pwdata[SPD_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // transmit side: pause frame request or half-duplex backpressure
   assign frame_go = pause_tx_req && tx_enable_reg && full_duplex_reg;
   assign backp_ok = bp_req && flow_ctrl_enable_reg && tx_enable_reg
                     && !full_duplex_reg;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (frame_go) begin
               state_next = ST_FRAME;
            end else if (backp_ok) begin
               state_next = ST_BACKP;
            end
         end
         ST_FRAME: begin
            // a frame already on the line always completes
            if (tx_pause_done) begin
               state_next = ST_IDLE;
            end
         end
         ST_BACKP: begin
            if (!backp_ok) begin
               state_next = ST_IDLE;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_pause_start <= 1'b0;
      end else begin
         tx_pause_start <= (state_reg == ST_IDLE) && frame_go;
      end
   end

   assign flow_ctrl_busy = (state_reg != ST_IDLE);
   assign backpressure   = (state_reg == ST_BACKP);
   assign tx_pause_time  = pause_time_field_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // receive side: decode pause frames and build the per-frame status
   assign ctrl_seen = rx_frame_end && rx_good && rx_is_pause
                      && flow_ctrl_enable_reg;
   assign pause_hit = ctrl_seen && full_duplex_reg;

   // status comes for every frame; the data path never drops anything here
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_status_valid  <= 1'b0;
         rx_status_filter <= 1'b0;
         rx_status_ctrl   <= 1'b0;
      end else begin
         rx_status_valid <= rx_frame_end;
         rx_status_ctrl  <= ctrl_seen;
         if (!rx_frame_end) begin
            rx_status_filter <= rx_status_filter;
         end else if (rx_filter_override) begin
            rx_status_filter <= rx_addr_pass;
         end else if (ctrl_seen) begin
            rx_status_filter <= pass_control_frames_reg;
         end else begin
            rx_status_filter <= rx_addr_pass;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // pause timer
   assign qif.load      = pause_hit;
   assign qif.quanta    = rx_pause_time;
   assign qif.speed_100 = speed_100_reg;
   assign tx_hold       = qif.paused;

   mpf_quanta_timer i_mpf_quanta_timer (
      .pclk    (pclk),
      .presetn (presetn),
      .q       (qif.tmr)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   AST_PT_WRITE: assert property (
      (access_wr && wr_sel == SEL_FLOW) |=> tx_pause_time == $past(pwdata[PT_MSB:PT_LSB]))
      else $error("pause time not taken from flow write");

   AST_BUSY_FRAME: assert property (
      tx_pause_start |-> flow_ctrl_busy throughout (##[0:1000] tx_pause_done))
      else $error("busy dropped before the pause frame was sent");

   AST_BUSY_CLEAR: assert property (
      (state_reg == ST_FRAME && tx_pause_done) |=> !flow_ctrl_busy)
      else $error("busy not cleared after pause frame");

   AST_BP_BUSY: assert property (
      $rose(backpressure) |-> $past(backp_ok) && flow_ctrl_busy)
      else $error("backpressure raised without cause or busy");

   AST_TXOFF: assert property (
      !tx_enable_reg |=> !tx_pause_start && !backpressure)
      else $error("pause or backpressure with transmitter off");

   AST_PASS_MARK: assert property (
      (ctrl_seen && !rx_filter_override)
      |=> rx_status_valid && rx_status_filter == $past(pass_control_frames_reg))
      else $error("filter bit does not follow pass control");

   AST_EVERY_FRAME: assert property (
      rx_frame_end |=> rx_status_valid)
      else $error("received frame got no status");

   AST_OVERRIDE: assert property (
      (rx_frame_end && rx_filter_override) |=> rx_status_filter == $past(rx_addr_pass))
      else $error("filter mode did not take precedence");

   AST_PAUSE_HOLD: assert property (
      (pause_hit && rx_pause_time != 16'h0000) |=> tx_hold [*2])
      else $error("valid pause did not stop the transmitter");

   AST_HD_NOPAUSE: assert property (
      (!full_duplex_reg && !tx_hold && !qif.load) |=> !tx_hold)
      else $error("pause started outside full duplex");

   AST_NO_DECODE: assert property (
      (rx_frame_end && !flow_ctrl_enable_reg) |=> !rx_status_ctrl)
      else $error("control frame decoded with flow control off");

   AST_BP_ENABLE: assert property (
      (state_reg == ST_IDLE && backp_ok && !frame_go) |=> backpressure)
      else $error("backpressure not asserted in half duplex");

   AST_BP_CAUSE: assert property (
      backpressure |-> $past(backp_ok))
      else $error("backpressure without enable, transmitter or half duplex");

   AST_BP_DROP: assert property (
      (backpressure && !backp_ok) |=> !backpressure)
      else $error("backpressure outlived its cause");

   AST_START_PULSE: assert property (
      tx_pause_start |=> !tx_pause_start)
      else $error("pause frame start longer than one cycle");

   AST_START_GATED: assert property (
      tx_pause_start |-> $past(tx_enable_reg) && $past(full_duplex_reg))
      else $error("pause frame started with transmitter off");

   AST_FRAME_BUSY: assert property (
      (state_reg == ST_FRAME && !tx_pause_done) |=> flow_ctrl_busy)
      else $error("busy fell while the pause frame was on the line");

   AST_BUSY_VISIBLE: assert property (
      (setup_phase && !pwrite && rd_sel == SEL_FLOW)
      |=> prdata[BUSY_BIT] == $past(flow_ctrl_busy))
      else $error("busy flag not shown in flow read");

   AST_CTRL_WITH_STATUS: assert property (
      rx_status_ctrl |-> rx_status_valid)
      else $error("control mark without frame status");

   AST_FILTER_STABLE: assert property (
      !rx_frame_end |=> $stable(rx_status_filter))
      else $error("filter bit moved between frames");

   AST_PASS_CLEAR: assert property (
      (ctrl_seen && !rx_filter_override && !pass_control_frames_reg) |=> !rx_status_filter)
      else $error("filter bit set with pass control clear");

   AST_DECODE_ON: assert property (
      (rx_frame_end && rx_good && rx_is_pause && flow_ctrl_enable_reg) |=> rx_status_ctrl)
      else $error("valid pause frame not decoded");

   AST_BAD_NO_PAUSE: assert property (
      (rx_frame_end && !rx_good && !tx_hold) |=> !tx_hold)
      else $error("errored frame started a pause");

   AST_PLAIN_NOT_CTRL: assert property (
      (rx_frame_end && !rx_is_pause) |=> !rx_status_ctrl)
      else $error("plain frame marked as control");

   AST_FLOW_CTRL_ENABLE_OFF_NOHOLD: assert property (
      (!flow_ctrl_enable_reg && !tx_hold) |=> !tx_hold)
      else $error("pause started with flow control off");

   // held-cycle count since the last load; saturates so long pauses cannot wrap
   logic [15:0] hold_cnt_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_cnt_reg <= 16'h0000;
      end else if (qif.load || !tx_hold) begin
         hold_cnt_reg <= 16'h0000;
      end else if (hold_cnt_reg != 16'hffff) begin
         hold_cnt_reg <= hold_cnt_reg + 16'h0001;
      end
   end

   // a reload with zero may end a pause at once, so only natural expiry is checked
   AST_SLOT_MIN: assert property (
      ($fell(tx_hold) && !$past(qif.load)) |-> $past(hold_cnt_reg) >= 16'(QCYC_100 - 11'h001))
      else $error("pause ended before one slot time");

endmodule

// File: testbench/mpf_mac_side.sv
// mpf_mac_side: behavioural mac transmit and receive side facing the flow unit
// assumes all lines move on pclk; rx qualifiers only count with rx_frame_end
module mpf_mac_side (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        tx_pause_start,
   input  wire logic [15:0] done_delay,
   output logic             tx_pause_done,
   output logic             rx_frame_end,
   output logic             rx_good,
   output logic             rx_is_pause,
   output logic      [15:0] rx_pause_time,
   output logic             rx_addr_pass,
   output logic             rx_filter_override
);
   timeunit 1ns;
   timeprecision 1ps;
   logic        run_reg;
   logic [15:0] cnt_reg;
   initial begin
      rx_frame_end = 1'b0;
      {rx_good, rx_is_pause, rx_pause_time, rx_addr_pass, rx_filter_override} = '0;
   end
   // done_delay picks a prompt or a slow end of the pause frame on the line
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_reg <= 1'b0;
         cnt_reg <= 16'h0;
         tx_pause_done <= 1'b0;
      end else begin
         tx_pause_done <= 1'b0;
         if (tx_pause_start) begin
            run_reg <= 1'b1;
            cnt_reg <= done_delay;
         end else if (run_reg && cnt_reg == 16'h0) begin
            run_reg <= 1'b0;
            tx_pause_done <= 1'b1;
         end else if (run_reg) begin
            cnt_reg <= cnt_reg - 16'h1;
         end
      end
   end
   // qualifiers go to their inverse outside a frame, never the stale value
   task send_frame(input logic g, input logic p, input logic [15:0] t, input logic a,
                   input logic o);
      @(posedge pclk);
      rx_frame_end <= 1'b1;
      {rx_good, rx_is_pause, rx_pause_time, rx_addr_pass, rx_filter_override} <= {g, p, t, a, o};
      @(posedge pclk);
      rx_frame_end <= 1'b0;
      {rx_good, rx_is_pause, rx_pause_time, rx_addr_pass, rx_filter_override} <= ~{g, p, t, a, o};
   endtask
endmodule

// File: testbench/mpf_flow_ctrl_tb_top.sv
// mpf_flow_ctrl_tb_top: self-checking bench for the pause flow control unit
// assumes mpf_pkg, the quanta interface and mpf_mac_side are compiled first
module mpf_flow_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import mpf_pkg::*;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic        pause_tx_req = 1'b0;
   logic        bp_req = 1'b0;
   logic [31:0] prdata;
   logic        pready, pslverr, tx_pause_start, backpressure, tx_hold;
   logic        rx_status_valid, rx_status_filter, rx_status_ctrl, tx_pause_done;
   logic        rx_frame_end, rx_good, rx_is_pause, rx_addr_pass, rx_filter_override;
   logic [15:0] tx_pause_time, rx_pause_time;
   logic [15:0] dly = 16'h0;
   logic [15:0] pt = 16'h0;
   logic        flow_ctrl_enable_v = 1'b0;
   logic        pass_v = 1'b0;
   logic [32:0] rdq[$];
   logic [1:0]  rxq[$];
   logic [32:0] e;
   int          num_errors = 0;
   int          comparisons = 0;
   int          starts = 0;
   int          q;

   always #20 pclk = ~pclk;

   mpf_flow_ctrl i_mpf_flow_ctrl (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .pready, .prdata, .pslverr, .pause_tx_req, .bp_req, .tx_pause_done, .tx_pause_start,
      .tx_pause_time, .backpressure, .tx_hold, .rx_frame_end, .rx_good, .rx_is_pause,
      .rx_pause_time, .rx_addr_pass, .rx_filter_override, .rx_status_valid,
      .rx_status_filter, .rx_status_ctrl);
   mpf_mac_side i_mpf_mac_side (.pclk, .presetn, .tx_pause_start, .done_delay(dly),
      .tx_pause_done, .rx_frame_end, .rx_good, .rx_is_pause, .rx_pause_time, .rx_addr_pass,
      .rx_filter_override);

   ////////////////////////////////////////////////////////////
   task chk(input string n, input logic [31:0] x, input logic [31:0] g);
      comparisons++;
      if (g !== x) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", n, x, g);
      end
   endtask
   task close_out;
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin chk("pready", 1, 0); close_out; end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [32:0] x);
      rdq.push_back(x);
      apb(1'b0, a, 32'h0);
   endtask
   function automatic logic [32:0] fexp(input logic busy);
      return {1'b0, pt, 13'h0, pass_v, flow_ctrl_enable_v, busy};
   endfunction
   task wr_flow;
      apb(1'b1, FLOW_ADDR, {pt, 13'h0, pass_v, flow_ctrl_enable_v, 1'b0});
   endtask
   task automatic waitsig(ref logic s, input string n);
      int k;
      k = 0;
      while (s !== 1'b1 && k < 200) begin @(negedge pclk); k++; end
      if (s !== 1'b1) begin chk(n, 1, 0); close_out; end
   endtask
   task rx(input logic g, input logic p, input logic [15:0] t, input logic a, input logic o);
      logic c;
      c = g & p & flow_ctrl_enable_v;
      rxq.push_back({o ? a : (c ? pass_v : a), c});
      i_mpf_mac_side.send_frame(g, p, t, a, o);
   endtask
   task hold_len(input int x);
      int n;
      int k;
      n = 0;
      k = 0;
      while (tx_hold !== 1'b1 && k < 5) begin @(negedge pclk); k++; end
      while (tx_hold === 1'b1 && n < 4000) begin @(negedge pclk); n++; end
      chk("tx_hold cycles", x, n);
   endtask

   ////////////////////////////////////////////////////////////
   // scoreboard: oldest note is matched to each answer as it appears
   always @(posedge pclk) begin
      if (psel && penable && !pwrite && pready === 1'b1) begin
         if (rdq.size() == 0) chk("read queue", 0, 1);
         else begin
            e = rdq.pop_front();
            chk("prdata", e[31:0], prdata);
            chk("pslverr", e[32], pslverr);
         end
      end
      if (rx_status_valid === 1'b1) begin
         if (rxq.size() == 0) chk("rx queue", 0, 1);
         else chk("rx filter,ctrl", rxq.pop_front(), {rx_status_filter, rx_status_ctrl});
      end
      if (tx_pause_start === 1'b1) starts++;
   end

   initial begin
      repeat (100000) @(posedge pclk);
      chk("timeout", 0, 1);
      close_out;
   end

   ////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'h120ce9db));
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd(MODE_ADDR, {1'b0, MODE_RST});
      rd(STAT_ADDR, 33'h0);
      rd(FLOW_ADDR, {1'b0, FLOW_RST});
      rd(8'h10, {1'b1, 32'h0});
      apb(1'b1, STAT_ADDR, 32'hffff_ffff);
      rd(STAT_ADDR, 33'h0);
      pt = 16'($urandom);
      {flow_ctrl_enable_v, pass_v} = 2'b11;
      wr_flow();
      rd(FLOW_ADDR, fexp(1'b0));
      chk("tx_pause_time", pt, tx_pause_time);
      // transmitter off: neither pause frame nor backpressure
      for (int m = 0; m < 2; m++) begin
         apb(1'b1, MODE_ADDR, (m == 0) ? 32'h1 : 32'h0);
         q = starts;
         {pause_tx_req, bp_req} <= 2'b11;
         repeat (8) @(posedge pclk);
         {pause_tx_req, bp_req} <= 2'b00;
         chk("starts", q, starts);
         chk("backpressure", 0, backpressure);
      end
      apb(1'b1, MODE_ADDR, 32'h7);
      for (int d = 0; d < 2; d++) begin
         dly = (d == 0) ? 16'd20 : 16'd0;
         q = starts;
         @(posedge pclk) pause_tx_req <= 1'b1;
         @(posedge pclk) pause_tx_req <= 1'b0;
         if (d == 0) rd(FLOW_ADDR, fexp(1'b1));
         waitsig(tx_pause_done, "tx_pause_done");
         rd(FLOW_ADDR, fexp(1'b0));
         chk("starts", q + 1, starts);
      end
      apb(1'b1, MODE_ADDR, 32'h2);
      bp_req <= 1'b1;
      repeat (3) @(posedge pclk);
      chk("backpressure", 1, backpressure);
      rd(FLOW_ADDR, fexp(1'b1));
      bp_req <= 1'b0;
      repeat (3) @(posedge pclk);
      chk("backpressure", 0, backpressure);
      rd(FLOW_ADDR, fexp(1'b0));
      flow_ctrl_enable_v = 1'b0;
      wr_flow();
      bp_req <= 1'b1;
      repeat (3) @(posedge pclk);
      chk("backpressure", 0, backpressure);
      bp_req <= 1'b0;
      // every flow_ctrl_enable, pass and override mix, plus plain and errored frames
      apb(1'b1, MODE_ADDR, 32'h3);
      for (int i = 0; i < 8; i++) begin
         {pass_v, flow_ctrl_enable_v} = i[1:0];
         wr_flow();
         rx(1'b1, 1'b1, 16'h0, 1'($urandom), i[2]);
         rx(1'b1, 1'b0, 16'h0, 1'($urandom), 1'b0);
         rx(1'b0, 1'b1, 16'h0, 1'($urandom), 1'b0);
      end
      {pass_v, flow_ctrl_enable_v} = 2'b11;
      wr_flow();
      apb(1'b1, MODE_ADDR, 32'h7);
      q = int'($urandom_range(3, 1));
      rx(1'b1, 1'b1, 16'(q), 1'b1, 1'b0);
      hold_len(q * SLOT_BITS * BIT_NS_100 / CLK_NS);
      apb(1'b1, MODE_ADDR, 32'h3);
      rx(1'b1, 1'b1, 16'h1, 1'b1, 1'b0);
      hold_len(SLOT_BITS * BIT_NS_10 / CLK_NS);
      apb(1'b1, MODE_ADDR, 32'h6);
      rx(1'b1, 1'b1, 16'h2, 1'b1, 1'b0);
      hold_len(0);
      flow_ctrl_enable_v = 1'b0;
      wr_flow();
      apb(1'b1, MODE_ADDR, 32'h7);
      rx(1'b1, 1'b1, 16'h2, 1'b0, 1'b0);
      hold_len(0);
      repeat (3) @(posedge pclk);
      chk("rx notes left", 0, rxq.size());
      close_out;
   end
endmodule
